/* logic/fpc_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Key in lockout position makes every momentary panel switch have no effect; select switches still pick the displayed register.
// - Lamps keep working with the key powered or in lockout.
// - Step while running finishes the current instruction, then halts.
// - Step while halted executes exactly the instruction register's instruction.
// - Step lamp lights on step press, goes out on run press.
// - Run executes the instruction register, then runs from the program counter.
// - Run lamp lights on run press, goes out on step press.
// - Five select switches choose index, B, A, instruction register or program counter.
// - Two or more select switches active disables selection and blanks display.
// - Bit clear in step mode zeroes the selected register; lamps go dark.
// - Sixteen lamps show the selected register, lit for each one bit.
// - Lamps and entry switches run bit 15 at left down to bit 0.
// - Each entry switch loads its own bit of the selected register.
// - No select switch down means no register is displayed.
// - Entry press sets its bit to one; only bit clear clears bits.
// - Repeat with step executes and advances program counter, instruction register kept.
// - Repeat switch has no effect in run mode.
// - System reset halts processor and peripherals, registers are kept.
module fpc_top
  import fpc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
  input  wire logic                CLK_I,
  input  wire logic                RESETN_I,
  input  wire logic [1:0]          KEY_POS_I,
  input  wire logic                STEP_SW_I,
  input  wire logic                RUN_SW_I,
  input  wire logic                CLR_SW_I,
  input  wire logic                SYSRST_SW_I,
  input  wire logic                REPEAT_SW_I,
  input  wire logic [NUM_SEL-1:0]  SEL_SW_I,
  input  wire logic [DATA_W-1:0]   ENTRY_SW_I,
  input  wire logic [DATA_W-1:0]   REG_INDEX_I,
  input  wire logic [DATA_W-1:0]   REG_ACCB_I,
  input  wire logic [DATA_W-1:0]   REG_ACCA_I,
  input  wire logic [DATA_W-1:0]   REG_INSTR_I,
  input  wire logic [DATA_W-1:0]   REG_PC_I,
  input  wire logic                INSTR_DONE_I,
  input  wire logic                HSEL_I,
  input  wire logic [31:0]         HADDR_I,
  input  wire logic [1:0]          HTRANS_I,
  input  wire logic                HWRITE_I,
  input  wire logic [2:0]          HSIZE_I,
  input  wire logic [31:0]         HWDATA_I,
  input  wire logic                HREADY_I,
  output logic [31:0]              HRDATA_O,
  output logic                     HREADYOUT_O,
  output logic                     HRESP_O,
  output fpc_cpu_cmd_t             CPU_CMD_O,
  output logic [DATA_W-1:0]        DISP_LAMP_O,
  output logic                     STEP_LAMP_O,
  output logic                     RUN_LAMP_O
);

  // ------------------------------------------------------------
  // Input synchronisers and debouncers
  // ------------------------------------------------------------
  localparam int unsigned NUM_MOM = 4 + DATA_W;
  localparam int unsigned NUM_LVL = NUM_SEL + 3;
  localparam logic [DB_CNT_W-1:0] DB_LIMIT = DB_CNT_W'(DEBOUNCE_CYCLES - 1);

  logic [NUM_MOM-1:0]  mom_raw;
  logic [NUM_MOM-1:0]  mom_s1_r;
  logic [NUM_MOM-1:0]  mom_s2_r;
  logic [NUM_MOM-1:0]  mom_db_r;
  logic [NUM_MOM-1:0]  mom_db_nxt;
  logic [NUM_MOM-1:0]  mom_prev_r;
  logic [NUM_MOM-1:0]  mom_pulse;
  logic [NUM_LVL-1:0]  lvl_raw;
  logic [NUM_LVL-1:0]  lvl_s1_r;
  logic [NUM_LVL-1:0]  lvl_s2_r;

  assign mom_raw = {ENTRY_SW_I, SYSRST_SW_I, CLR_SW_I, RUN_SW_I, STEP_SW_I};
  assign lvl_raw = {KEY_POS_I, REPEAT_SW_I, SEL_SW_I};

  // A press must stay stable for the whole window, so contact bounce never doubles it.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MOM; gi++)
    begin : g_db
      logic [DB_CNT_W-1:0] cnt_r;
      logic [DB_CNT_W-1:0] cnt_nxt;
      always_comb
      begin
        cnt_nxt       = '0;
        mom_db_nxt[gi] = mom_db_r[gi];
        if (mom_s2_r[gi] != mom_db_r[gi])
        begin
          cnt_nxt = cnt_r + DB_CNT_W'(1);
          if (cnt_r >= DB_LIMIT)
          begin
            cnt_nxt        = '0;
            mom_db_nxt[gi] = mom_s2_r[gi];
          end
        end
      end
      always_ff @(posedge CLK_I or negedge RESETN_I)
      begin
        if (!RESETN_I)
          cnt_r <= '0;
        else
          cnt_r <= cnt_nxt;
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      mom_s1_r   <= '0;
      mom_s2_r   <= '0;
      mom_db_r   <= '0;
      mom_prev_r <= '0;
      lvl_s1_r   <= '0;
      lvl_s2_r   <= '0;
    end
    else
    begin
      mom_s1_r   <= mom_raw;
      mom_s2_r   <= mom_s1_r;
      mom_db_r   <= mom_db_nxt;
      mom_prev_r <= mom_db_r;
      lvl_s1_r   <= lvl_raw;
      lvl_s2_r   <= lvl_s1_r;
    end
  end

  assign mom_pulse = mom_db_r & ~mom_prev_r;

  // ------------------------------------------------------------
  // Panel decoding
  // ------------------------------------------------------------
  logic [NUM_SEL-1:0] sel_sw;
  logic               repeat_sw;
  logic [1:0]         key_pos;
  logic               lockout;
  logic               sel_one;
  logic [2:0]         sel_idx;
  fpc_keys_t          keys;
  logic [DATA_W-1:0]  entry_pulse;

  assign sel_sw      = lvl_s2_r[NUM_SEL-1:0];
  assign repeat_sw   = lvl_s2_r[NUM_SEL];
  assign key_pos     = lvl_s2_r[NUM_SEL+2:NUM_SEL+1];
  assign lockout     = (key_pos == KEY_LOCKOUT);
  // Lockout gates every momentary action here, at one point.
  assign keys        = lockout ? '0 : {mom_pulse[0], mom_pulse[1], mom_pulse[2], mom_pulse[3]};
  assign entry_pulse = lockout ? '0 : mom_pulse[NUM_MOM-1:4];

  always_comb
  begin
    sel_one = 1'b0;
    sel_idx = SEL_INDEX;
    case (sel_sw)
      5'h01: begin sel_one = 1'b1; sel_idx = SEL_INDEX; end
      5'h02: begin sel_one = 1'b1; sel_idx = SEL_ACCB;  end
      5'h04: begin sel_one = 1'b1; sel_idx = SEL_ACCA;  end
      5'h08: begin sel_one = 1'b1; sel_idx = SEL_INSTR; end
      5'h10: begin sel_one = 1'b1; sel_idx = SEL_PC;    end
      default: sel_one = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Run and step control
  // ------------------------------------------------------------
  fpc_mode_t          mode_r;
  fpc_mode_t          mode_nxt;
  fpc_cpu_cmd_t       cmd_r;
  fpc_cpu_cmd_t       cmd_nxt;
  logic               step_lamp_r;
  logic               step_lamp_nxt;
  logic               run_lamp_r;
  logic               run_lamp_nxt;
  logic [DATA_W-1:0]  cur_val;
  logic [DATA_W-1:0]  disp_r;
  logic [DATA_W-1:0]  disp_nxt;

  always_comb
  begin
    case (sel_idx)
      SEL_INDEX: cur_val = REG_INDEX_I;
      SEL_ACCB:  cur_val = REG_ACCB_I;
      SEL_ACCA:  cur_val = REG_ACCA_I;
      SEL_INSTR: cur_val = REG_INSTR_I;
      default:   cur_val = REG_PC_I;
    endcase
  end

  always_comb
  begin
    mode_nxt      = mode_r;
    cmd_nxt       = '0;
    step_lamp_nxt = step_lamp_r;
    run_lamp_nxt  = run_lamp_r;
    if (keys.sysrst)
    begin
      cmd_nxt.sys_reset = 1'b1;
      mode_nxt          = MODE_STEP;
      run_lamp_nxt      = 1'b0;
    end
    else if (keys.step)
    begin
      step_lamp_nxt = 1'b1;
      run_lamp_nxt  = 1'b0;
      if (mode_r == MODE_RUN)
      begin
        cmd_nxt.halt_req = 1'b1;
        mode_nxt         = MODE_WAIT;
      end
      else if (mode_r == MODE_STEP)
      begin
        cmd_nxt.start       = 1'b1;
        cmd_nxt.halt_req    = 1'b1;
        cmd_nxt.repeat_step = repeat_sw;
        mode_nxt            = MODE_WAIT;
      end
      // A completion landing with a step press must not be lost, or the panel would wait forever.
      else if (INSTR_DONE_I)
        mode_nxt = MODE_STEP;
    end
    else if (keys.run && mode_r == MODE_STEP)
    begin
      step_lamp_nxt = 1'b0;
      run_lamp_nxt  = 1'b1;
      cmd_nxt.start = 1'b1;
      mode_nxt      = MODE_RUN;
    end
    else if (mode_r == MODE_WAIT && INSTR_DONE_I)
      mode_nxt = MODE_STEP;
    if (mode_r == MODE_STEP && sel_one && (keys.clr || entry_pulse != '0))
    begin
      cmd_nxt.wr_en   = 1'b1;
      cmd_nxt.wr_sel  = sel_idx;
      // Clear wins over a set arriving in the same cycle.
      cmd_nxt.wr_data = keys.clr ? '0 : (cur_val | entry_pulse);
    end
    // Lamps follow the register regardless of the key position.
    disp_nxt = sel_one ? cur_val : '0;
    if (cmd_nxt.wr_en)
      disp_nxt = cmd_nxt.wr_data;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      mode_r      <= MODE_STEP;
      cmd_r       <= '0;
      step_lamp_r <= 1'b1;
      run_lamp_r  <= 1'b0;
      disp_r      <= '0;
    end
    else
    begin
      mode_r      <= mode_nxt;
      cmd_r       <= cmd_nxt;
      step_lamp_r <= step_lamp_nxt;
      run_lamp_r  <= run_lamp_nxt;
      disp_r      <= disp_nxt;
    end
  end

  assign CPU_CMD_O   = cmd_r;
  assign DISP_LAMP_O = disp_r;
  assign STEP_LAMP_O = step_lamp_r;
  assign RUN_LAMP_O  = run_lamp_r;

  // ------------------------------------------------------------
  // Bus slave, read only status and display
  // ------------------------------------------------------------
  logic        rd_req;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] status_w;

  assign status_w = {24'h000000, lockout, repeat_sw, 1'b0, sel_one, run_lamp_r, step_lamp_r, mode_r};

  // Read data is captured at the address phase, so the data phase is served straight from a register.
  always_comb
  begin
    rd_req    = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
    rdata_nxt = rdata_r;
    if (rd_req)
    begin
      case (HADDR_I[7:0])
        ADDR_STATUS: rdata_nxt = status_w;
        ADDR_DISP:   rdata_nxt = {16'h0000, disp_r};
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rdata_r <= STATUS_RST;
    else
      rdata_r <= rdata_nxt;
  end

  assign HRDATA_O    = rdata_r;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

endmodule : fpc_top
`default_nettype wire

/* shared/fpc_pkg.sv */
`default_nettype none
package fpc_pkg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SEL   = 5;
  localparam int unsigned DATA_W    = 16;
  localparam logic [2:0]  SEL_INDEX = 3'h0;
  localparam logic [2:0]  SEL_ACCB  = 3'h1;
  localparam logic [2:0]  SEL_ACCA  = 3'h2;
  localparam logic [2:0]  SEL_INSTR = 3'h3;
  localparam logic [2:0]  SEL_PC    = 3'h4;

  // ----------------------------------------------------------------
  // Key switch positions
  // ----------------------------------------------------------------
  localparam logic [1:0]  KEY_OFF      = 2'h0;
  localparam logic [1:0]  KEY_POWERED  = 2'h1;
  localparam logic [1:0]  KEY_LOCKOUT  = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned DEBOUNCE_US    = 5000;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned DB_CNT_W       = 20;

  // ----------------------------------------------------------------
  // Register bus map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS = 8'h00;
  localparam logic [7:0]  ADDR_DISP   = 8'h04;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_STEP = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_RUN  = 2'b10
  } fpc_mode_t;

  typedef struct packed
  {
    logic step;
    logic run;
    logic clr;
    logic sysrst;
  } fpc_keys_t;

  typedef struct packed
  {
    logic                start;
    logic                halt_req;
    logic                repeat_step;
    logic                sys_reset;
    logic                wr_en;
    logic [2:0]          wr_sel;
    logic [DATA_W-1:0]   wr_data;
  } fpc_cpu_cmd_t;

endpackage : fpc_pkg
`default_nettype wire

/* test/fpc_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fpc_cpu_model
  import fpc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire fpc_cpu_cmd_t         cmd_i,
  input  wire logic [2:0]           dly_i,
  output logic [NUM_SEL*DATA_W-1:0] regs_o,
  output logic                      done_o
);
  // ----------------------------------------
  // Sequencer stand-in
  // ----------------------------------------
  // Registers are never cleared by the system reset pulse.
  logic [2:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      regs_o <= '0;
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (cmd_i.wr_en)
        regs_o[int'(cmd_i.wr_sel)*DATA_W +: DATA_W] <= cmd_i.wr_data;
      if (cmd_i.halt_req)
      begin
        busy_r <= 1'b1;
        cnt_r  <= dly_i;
      end
      else if (busy_r && cnt_r == 3'h0)
      begin
        busy_r <= 1'b0;
        done_o <= 1'b1;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule : fpc_cpu_model
`default_nettype wire

/* test/fpc_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module fpc_top_chk
  import fpc_pkg::*;
(
  input wire logic               CLK_I,
  input wire logic               RESETN_I,
  input wire logic [1:0]         KEY_POS_I,
  input wire logic [NUM_SEL-1:0] SEL_SW_I,
  input wire logic [DATA_W-1:0]  REG_INDEX_I,
  input wire logic               HREADYOUT_O,
  input wire logic               HRESP_O,
  input wire fpc_cpu_cmd_t       CPU_CMD_O,
  input wire logic [DATA_W-1:0]  DISP_LAMP_O,
  input wire logic               STEP_LAMP_O,
  input wire logic               RUN_LAMP_O
);
  // ----------------------------------------
  // Panel checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Held long enough to pass the two-stage synchroniser.
  sequence s_lock;
    (KEY_POS_I == KEY_LOCKOUT) [*8];
  endsequence
  sequence s_multi;
    ($countones(SEL_SW_I) > 1) [*5];
  endsequence
  sequence s_idx;
    (SEL_SW_I == 5'h01 && !CPU_CMD_O.wr_en && $stable(REG_INDEX_I)) [*5];
  endsequence
  a_lock_quiet: assert property (s_lock |-> !(CPU_CMD_O.start || CPU_CMD_O.halt_req || CPU_CMD_O.wr_en))
    else $error("panel action under lockout");
  a_multi_blank: assert property (s_multi |-> DISP_LAMP_O == 16'h0000)
    else $error("display lit with several selects");
  a_none_blank: assert property ((SEL_SW_I == 5'h00) [*5] |-> DISP_LAMP_O == 16'h0000)
    else $error("display lit with no select");
  a_disp_follow: assert property (s_idx |-> DISP_LAMP_O == REG_INDEX_I)
    else $error("display differs from selected register");
  a_run_lamp: assert property (CPU_CMD_O.start && !CPU_CMD_O.halt_req |-> ##[0:2] RUN_LAMP_O)
    else $error("run lamp not lit after run");
  a_halt_lamp: assert property (CPU_CMD_O.halt_req |-> ##[0:2] (STEP_LAMP_O && !RUN_LAMP_O))
    else $error("step lamp wrong after step");
  a_lamps_excl: assert property (!(STEP_LAMP_O && RUN_LAMP_O))
    else $error("both mode lamps lit");
  a_wr_halted: assert property (CPU_CMD_O.wr_en |-> !RUN_LAMP_O)
    else $error("register write while running");
  a_rep_step: assert property (CPU_CMD_O.repeat_step |-> CPU_CMD_O.start && CPU_CMD_O.halt_req)
    else $error("repeat outside a halted step");
  a_start_pulse: assert property (CPU_CMD_O.start |=> !CPU_CMD_O.start)
    else $error("start longer than one cycle");
  a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or not okay");
endmodule : fpc_top_chk
bind fpc_top fpc_top_chk u_fpc_top_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .KEY_POS_I(KEY_POS_I),
  .SEL_SW_I(SEL_SW_I), .REG_INDEX_I(REG_INDEX_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .CPU_CMD_O(CPU_CMD_O), .DISP_LAMP_O(DISP_LAMP_O), .STEP_LAMP_O(STEP_LAMP_O), .RUN_LAMP_O(RUN_LAMP_O));
`default_nettype wire

/* test/test_fpc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module test_fpc_top
  import fpc_pkg::*;
;
  logic clk, rstn, hsel, hw, hrdy, hresp, slamp, rlamp, done;
  logic step, run, clr, sysr, rep;
  logic [1:0] key, htr;
  logic [2:0] hsz, dly;
  logic [4:0] sel;
  logic [15:0] ent, disp;
  logic [31:0] ha, hwd, hrd, seed, v, d;
  logic [79:0] regs;
  logic [7:0] c_st, c_hr, c_rp, c_sy;
  fpc_cpu_cmd_t cmd;
  integer n_fail, n_tests, k;
  fpc_top #(.DEBOUNCE_CYCLES(4)) u_fpc_top (.CLK_I(clk), .RESETN_I(rstn), .KEY_POS_I(key),
    .STEP_SW_I(step), .RUN_SW_I(run), .CLR_SW_I(clr), .SYSRST_SW_I(sysr), .REPEAT_SW_I(rep),
    .SEL_SW_I(sel), .ENTRY_SW_I(ent), .REG_INDEX_I(regs[15:0]), .REG_ACCB_I(regs[31:16]),
    .REG_ACCA_I(regs[47:32]), .REG_INSTR_I(regs[63:48]), .REG_PC_I(regs[79:64]),
    .INSTR_DONE_I(done), .HSEL_I(hsel), .HADDR_I(ha), .HTRANS_I(htr), .HWRITE_I(hw),
    .HSIZE_I(hsz), .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp), .CPU_CMD_O(cmd), .DISP_LAMP_O(disp), .STEP_LAMP_O(slamp), .RUN_LAMP_O(rlamp));
  fpc_cpu_model u_fpc_cpu_model (.clk_i(clk), .rstn_i(rstn), .cmd_i(cmd), .dly_i(dly),
    .regs_o(regs), .done_o(done));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (!rstn)
      {c_st, c_hr, c_rp, c_sy} <= '0;
    else
    begin
      c_st <= c_st + {7'h00, cmd.start};
      c_hr <= c_hr + {7'h00, cmd.halt_req};
      c_rp <= c_rp + {7'h00, cmd.repeat_step};
      c_sy <= c_sy + {7'h00, cmd.sys_reset};
    end
  end
  task close_out();
    $display("Counts: %0d compared, %0d wrong", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  function logic [31:0] exp_status(input logic lk, input logic rp, input logic so, input logic [1:0] lamps,
    input logic [1:0] md);
    return {24'h000000, lk, rp, 1'b0, so, lamps, md};
  endfunction : exp_status
  task press(input logic [3:0] m, input logic [15:0] e);
    {sysr, clr, run, step} <= m;
    ent <= e;
    repeat (12) @(posedge clk);
    {sysr, clr, run, step} <= 4'h0;
    ent <= 16'h0000;
    repeat (12) @(posedge clk);
  endtask : press
  task wait_rdy();
    repeat (50) if (hrdy !== 1'b1) @(posedge clk);
    if (hrdy !== 1'b1)
    begin
      n_fail++;
      close_out();
    end
  endtask : wait_rdy
  task ahb_rd(input logic [31:0] a, output logic [31:0] q);
    hsel <= 1'b1;
    htr <= 2'h2;
    ha <= a;
    @(posedge clk);
    wait_rdy();
    htr <= 2'h0;
    @(posedge clk);
    wait_rdy();
    q = hrd;
  endtask : ahb_rd
  initial
  begin
    {rstn, hsel, hw, step, run, clr, sysr, rep, htr, sel, ent, ha, hwd} = '0;
    {n_fail, n_tests} = '0;
    hsz = 3'h2;
    key = KEY_POWERED;
    seed = 32'h285C;
    dly = 3'h7;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(slamp, 1);
    chk(rlamp, 0);
    ahb_rd({24'h0, ADDR_STATUS}, d);
    chk(d, exp_status(1'b0, 1'b0, 1'b0, 2'b01, MODE_STEP));
    for (k = 0; k < 5; k++)
    begin
      v = $random(seed);
      sel <= 5'h01 << k;
      press(4'h4, 16'h0000);
      chk(regs[k*16 +: 16], 0);
      press(4'h0, v[15:0]);
      chk(regs[k*16 +: 16], v[15:0]);
      chk(disp, v[15:0]);
    end
    press(4'h0, 16'h8001);
    chk(regs[79:64], v[15:0] | 16'h8001);
    sel <= 5'h03;
    repeat (6) @(posedge clk);
    chk(disp, 0);
    sel <= 5'h00;
    repeat (6) @(posedge clk);
    chk(disp, 0);
    sel <= 5'h01;
    repeat (6) @(posedge clk);
    ahb_rd({24'h0, ADDR_DISP}, d);
    chk(d, {16'h0, regs[15:0]});
    ahb_rd(32'h40, d);
    chk(d, 0);
    $display("Test entry and display done");
    v = $random(seed);
    dly <= v[2:0];
    rep <= 1'b1;
    press(4'h1, 16'h0000);
    chk({c_st, c_hr, c_rp}, 24'h010101);
    press(4'h2, 16'h0000);
    chk({c_st, c_rp, rlamp, slamp}, 18'h00806);
    ahb_rd({24'h0, ADDR_STATUS}, d);
    chk(d, exp_status(1'b0, 1'b1, 1'b1, 2'b10, MODE_RUN));
    v = {16'h0000, regs[15:0]};
    press(4'h4, 16'hFFFF);
    chk(regs[15:0], v[15:0]);
    press(4'h1, 16'h0000);
    chk({c_st, c_hr, rlamp, slamp}, 18'h00809);
    chk(c_rp, 1);
    key <= KEY_LOCKOUT;
    repeat (4) @(posedge clk);
    press(4'h2, 16'h0000);
    chk({c_st, rlamp}, 9'h004);
    chk(disp, regs[15:0]);
    key <= KEY_POWERED;
    repeat (4) @(posedge clk);
    press(4'h8, 16'h0000);
    chk(c_sy, 1);
    chk(regs[15:0], v[15:0]);
    $display("Test control sequence done");
    close_out();
  end
endmodule : test_fpc_top
`default_nettype wire
